// *** design/ccu_pkg.sv ***
// ---------------------------------------------------------------
// Register map, field layout and timing constants
// ---------------------------------------------------------------
package ccu_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_MATCH_LO = 8'h04;
    localparam logic [7:0] OFF_MATCH_HI = 8'h08;
    localparam logic [7:0] OFF_TIMER_LO = 8'h0C;
    localparam logic [7:0] OFF_TIMER_HI = 8'h10;
    localparam logic [7:0] OFF_TIMER_CFG = 8'h14;
    localparam logic [7:0] OFF_ALT_PIN = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_CONV_CTRL = 8'h20;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DUTY_LSB = 4;
    localparam int CTRL_BRIDGE_LSB = 6;
    localparam int TCFG_ON_BIT = 0;
    localparam int TCFG_EXT_BIT = 1;
    localparam int ALT_SEL_BIT = 0;
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int CONV_ON_BIT = 0;
    localparam int CONV_GO_BIT = 1;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_TIMER = 16'h0000;
    localparam logic [3:0] RST_PRESC = 4'h0;
    localparam logic [1:0] RST_DIV = 2'h0;

    // Mode field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SWIRQ = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

    // Prescaler terminal counts (count of edges minus one)
    localparam logic [3:0] PRESC_LAST_4 = 4'h3;
    localparam logic [3:0] PRESC_LAST_16 = 4'hF;

    // Instruction clock is one quarter of the system clock
    localparam int SYS_CLK_MHZ = 250;
    localparam int INST_CLK_DIV = 4;
    localparam logic [1:0] INST_DIV_LAST = 2'(INST_CLK_DIV - 1);

    // Timer extremes
    localparam logic [15:0] TIMER_MAX = 16'hFFFF;

endpackage

// *** design/ccu_sync.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two flip-flop synchroniser for asynchronous pin levels
// ---------------------------------------------------------------
module ccu_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// *** design/ccu_unit.sv ***
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Mode field low nibble of control picks one of four capture prescale settings.
// - Prescaler counter held at zero when unit off or not capturing.
// - Any reset clears the capture prescaler counter.
// - Changing capture prescale directly keeps the counter; a false capture may follow.
// - Timer clocks from the quarter-rate instruction tick or an external clock.
// - On instruction tick the timer freezes in sleep and resumes afterwards.
// - With the external clock the timer and capture keep running in sleep.
// - Compare mode checks the 16-bit match pair against the timer for equality.
// - A match toggles, sets or clears the latch, triggers, or only interrupts.
// - Every compare match sets the interrupt flag with the action.
// - Special trigger resets the timer without setting the overflow flag.
// - Unit five trigger also sets the converter start bit, bit one, when the converter is on.
// - The pin function can be moved to an alternate pin.
// - Writing zero to control forces the compare output latch low.
// - Control holds bridge mode 7:6, duty low bits 5:4, mode 3:0.
// - Capture on each falling, each rising, fourth or sixteenth rising edge.
// - Capture copies the timer into the match pair, sets the flag, overwrites.
// - Software interrupt and special trigger modes leave the pin undriven.
// - Trigger resets the timer on its next tick; a match pair write cancels.
module ccu_unit #(
    parameter bit UNIT_IS_FIVE = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    // Unit pin, primary and alternate
    input wire logic pin_pri_in,
    output logic pin_pri_out_q,
    output logic pin_pri_oe_q,
    input wire logic pin_alt_in,
    output logic pin_alt_out_q,
    output logic pin_alt_oe_q,
    // Timer clocking
    input wire logic ext_timer_clk,
    input wire logic sleep_mode,
    // Status to the rest of the chip
    output logic unit_irq_flag_q,
    output logic timer_overflow_flag_q,
    output logic converter_start_q,
    output logic special_event_q
);

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [7:0] unit_control_q;
    logic [7:0] match_value_low_q;
    logic [7:0] match_value_high_q;
    logic [15:0] timer_q;
    logic timer_on_q;
    logic timer_ext_q;
    logic alt_pin_select_q;
    logic converter_on_q;
    logic [3:0] presc_q;
    logic [1:0] div_q;
    logic ext_prev_q;
    logic pin_prev_q;
    logic timer_moved_q;
    logic sev_pending_q;
    logic compare_latch_q;

    // ---------------------------------------------------------------
    // Decoded control and bus strobes
    // ---------------------------------------------------------------
    logic [3:0] unit_mode_field;
    logic [1:0] duty_low_bits;
    logic [1:0] bridge_output_mode;
    logic [2:0] pins_sync;
    logic access;
    logic wr_en;
    logic wr_control;
    logic wr_match;
    logic [7:0] wbyte;
    logic [31:0] rd_data;
    logic rd_hit;

    assign unit_mode_field = unit_control_q[ccu_pkg::CTRL_MODE_LSB +: 4];
    assign duty_low_bits = unit_control_q[ccu_pkg::CTRL_DUTY_LSB +: 2];
    assign bridge_output_mode = unit_control_q[ccu_pkg::CTRL_BRIDGE_LSB +: 2];

    // A write lands only at the completing edge; only the low lane holds data
    assign access = psel & penable;
    assign wr_en = access & pready_q & pwrite & pstrb[0];
    assign wbyte = pwdata[7:0];
    assign wr_control = wr_en & (paddr == ccu_pkg::OFF_CONTROL);
    assign wr_match = wr_en & ((paddr == ccu_pkg::OFF_MATCH_LO) |
                               (paddr == ccu_pkg::OFF_MATCH_HI));

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    ccu_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({ext_timer_clk, pin_alt_in, pin_pri_in}),
        .sync_out(pins_sync)
    );

    // ---------------------------------------------------------------
    // Mode classification
    // ---------------------------------------------------------------
    logic capture_mode;
    logic compare_mode;
    logic drives_pin;
    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    // Capture codes all sit in 01xx
    assign capture_mode = (unit_mode_field[3:2] == 2'b01);
    assign compare_mode = unit_mode_field[3] | (unit_mode_field == ccu_pkg::MODE_CMP_TOGGLE);
    // Software interrupt and special trigger never claim the pin
    assign drives_pin = (unit_mode_field == ccu_pkg::MODE_CMP_TOGGLE) |
                        (unit_mode_field == ccu_pkg::MODE_CMP_SET) |
                        (unit_mode_field == ccu_pkg::MODE_CMP_CLEAR);

    // Input taken from whichever pin carries the function
    assign pin_level = alt_pin_select_q ? pins_sync[1] : pins_sync[0];
    assign pin_rise = pin_level & ~pin_prev_q;
    assign pin_fall = ~pin_level & pin_prev_q;

    // ---------------------------------------------------------------
    // Timer clocking
    // ---------------------------------------------------------------
    logic inst_tick;
    logic ext_tick;
    logic timer_tick;
    logic timer_wrap;

    assign inst_tick = (div_q == ccu_pkg::INST_DIV_LAST);
    assign ext_tick = pins_sync[2] & ~ext_prev_q;
    // Instruction tick stalls in sleep; the external clock does not
    assign timer_tick = timer_on_q &
                        (timer_ext_q ? ext_tick : (inst_tick & ~sleep_mode));
    assign timer_wrap = timer_tick & ~sev_pending_q & (timer_q == ccu_pkg::TIMER_MAX);

    // Quarter-rate divider runs freely
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_q <= ccu_pkg::RST_DIV;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    // Edge history of the synchronised levels
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_prev_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= pins_sync[2];
            pin_prev_q <= pin_level;
        end
    end

    // Timer count; a pending trigger turns the next tick into a reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            timer_q <= ccu_pkg::RST_TIMER;
        end else if (wr_en && paddr == ccu_pkg::OFF_TIMER_LO) begin
            timer_q[7:0] <= wbyte;
        end else if (wr_en && paddr == ccu_pkg::OFF_TIMER_HI) begin
            timer_q[15:8] <= wbyte;
        end else if (timer_tick) begin
            if (sev_pending_q) begin
                timer_q <= ccu_pkg::RST_TIMER;
            end else begin
                timer_q <= timer_q + 16'h0001;
            end
        end
    end

    // Overflow flag: the trigger reset never sets it, set beats clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            timer_overflow_flag_q <= 1'b0;
        end else if (timer_wrap) begin
            timer_overflow_flag_q <= 1'b1;
        end else if (wr_en && paddr == ccu_pkg::OFF_STATUS && wbyte[ccu_pkg::STAT_OVF_BIT]) begin
            timer_overflow_flag_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Compare
    // ---------------------------------------------------------------
    logic match_hit;
    logic special_hit;

    // Comparing only after a count change keeps one hit per timer value
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            timer_moved_q <= 1'b0;
        end else begin
            timer_moved_q <= timer_tick;
        end
    end

    assign match_hit = timer_moved_q & compare_mode &
                       ({match_value_high_q, match_value_low_q} == timer_q);
    assign special_hit = match_hit & (unit_mode_field == ccu_pkg::MODE_CMP_SPECIAL);

    // Trigger reset waits for the next timer tick; rewriting the pair cancels it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sev_pending_q <= 1'b0;
        end else if (wr_match) begin
            sev_pending_q <= 1'b0;
        end else if (special_hit) begin
            sev_pending_q <= 1'b1;
        end else if (timer_tick) begin
            sev_pending_q <= 1'b0;
        end
    end

    // Match action on the output latch
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            compare_latch_q <= 1'b0;
        end else if (wr_control && wbyte == ccu_pkg::RST_BYTE) begin
            compare_latch_q <= 1'b0;
        end else if (match_hit) begin
            case (unit_mode_field)
                ccu_pkg::MODE_CMP_SET: begin
                    compare_latch_q <= 1'b1;
                end
                ccu_pkg::MODE_CMP_CLEAR: begin
                    compare_latch_q <= 1'b0;
                end
                ccu_pkg::MODE_CMP_TOGGLE: begin
                    compare_latch_q <= ~compare_latch_q;
                end
                default: begin
                    compare_latch_q <= compare_latch_q;
                end
            endcase
        end
    end

    // Pin drive follows the latch and the alternate pin choice
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_pri_out_q <= 1'b0;
            pin_pri_oe_q <= 1'b0;
            pin_alt_out_q <= 1'b0;
            pin_alt_oe_q <= 1'b0;
        end else begin
            pin_pri_out_q <= compare_latch_q;
            pin_alt_out_q <= compare_latch_q;
            pin_pri_oe_q <= drives_pin & ~alt_pin_select_q;
            pin_alt_oe_q <= drives_pin & alt_pin_select_q;
        end
    end

    // Trigger strobe for the converter and the outside world
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            special_event_q <= 1'b0;
        end else begin
            special_event_q <= special_hit;
        end
    end

    // ---------------------------------------------------------------
    // Capture
    // ---------------------------------------------------------------
    logic capture_evt;
    logic presc_done4;
    logic presc_done16;

    // Greater-or-equal lets a stale count from a wider setting fire at once
    assign presc_done4 = (presc_q >= ccu_pkg::PRESC_LAST_4);
    assign presc_done16 = (presc_q >= ccu_pkg::PRESC_LAST_16);

    always_comb begin
        capture_evt = 1'b0;
        case (unit_mode_field)
            ccu_pkg::MODE_CAP_FALL: begin
                capture_evt = pin_fall;
            end
            ccu_pkg::MODE_CAP_RISE: begin
                capture_evt = pin_rise;
            end
            ccu_pkg::MODE_CAP_RISE4: begin
                capture_evt = pin_rise & presc_done4;
            end
            ccu_pkg::MODE_CAP_RISE16: begin
                capture_evt = pin_rise & presc_done16;
            end
            default: begin
                capture_evt = 1'b0;
            end
        endcase
    end

    // Prescaler counter: no clear when hopping between capture settings
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            presc_q <= ccu_pkg::RST_PRESC;
        end else if (!capture_mode) begin
            presc_q <= ccu_pkg::RST_PRESC;
        end else if (pin_rise) begin
            if (capture_evt) begin
                presc_q <= ccu_pkg::RST_PRESC;
            end else begin
                presc_q <= presc_q + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            unit_control_q <= ccu_pkg::RST_BYTE;
        end else if (wr_control) begin
            unit_control_q <= wbyte;
        end
    end

    // Match pair: a capture overwrites whatever software left there
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            match_value_low_q <= ccu_pkg::RST_BYTE;
            match_value_high_q <= ccu_pkg::RST_BYTE;
        end else if (capture_evt) begin
            match_value_low_q <= timer_q[7:0];
            match_value_high_q <= timer_q[15:8];
        end else if (wr_en && paddr == ccu_pkg::OFF_MATCH_LO) begin
            match_value_low_q <= wbyte;
        end else if (wr_en && paddr == ccu_pkg::OFF_MATCH_HI) begin
            match_value_high_q <= wbyte;
        end
    end

    // Timer setup and pin routing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            timer_on_q <= 1'b0;
            timer_ext_q <= 1'b0;
            alt_pin_select_q <= 1'b0;
        end else if (wr_en && paddr == ccu_pkg::OFF_TIMER_CFG) begin
            timer_on_q <= wbyte[ccu_pkg::TCFG_ON_BIT];
            timer_ext_q <= wbyte[ccu_pkg::TCFG_EXT_BIT];
        end else if (wr_en && paddr == ccu_pkg::OFF_ALT_PIN) begin
            alt_pin_select_q <= wbyte[ccu_pkg::ALT_SEL_BIT];
        end
    end

    // Unit interrupt flag: capture or any compare match; set beats clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            unit_irq_flag_q <= 1'b0;
        end else if (capture_evt || match_hit) begin
            unit_irq_flag_q <= 1'b1;
        end else if (wr_en && paddr == ccu_pkg::OFF_STATUS && wbyte[ccu_pkg::STAT_IRQ_BIT]) begin
            unit_irq_flag_q <= 1'b0;
        end
    end

    // Converter control: the trigger starts a conversion only when enabled
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            converter_on_q <= 1'b0;
            converter_start_q <= 1'b0;
        end else begin
            if (wr_en && paddr == ccu_pkg::OFF_CONV_CTRL) begin
                converter_on_q <= wbyte[ccu_pkg::CONV_ON_BIT];
            end
            if (UNIT_IS_FIVE && special_hit && converter_on_q) begin
                converter_start_q <= 1'b1;
            end else if (wr_en && paddr == ccu_pkg::OFF_CONV_CTRL) begin
                converter_start_q <= wbyte[ccu_pkg::CONV_GO_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // APB read path and handshake
    // ---------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            ccu_pkg::OFF_CONTROL: begin
                rd_data[7:0] = {bridge_output_mode, duty_low_bits, unit_mode_field};
            end
            ccu_pkg::OFF_MATCH_LO: begin
                rd_data[7:0] = match_value_low_q;
            end
            ccu_pkg::OFF_MATCH_HI: begin
                rd_data[7:0] = match_value_high_q;
            end
            ccu_pkg::OFF_TIMER_LO: begin
                rd_data[7:0] = timer_q[7:0];
            end
            ccu_pkg::OFF_TIMER_HI: begin
                rd_data[7:0] = timer_q[15:8];
            end
            ccu_pkg::OFF_TIMER_CFG: begin
                rd_data[ccu_pkg::TCFG_ON_BIT] = timer_on_q;
                rd_data[ccu_pkg::TCFG_EXT_BIT] = timer_ext_q;
            end
            ccu_pkg::OFF_ALT_PIN: begin
                rd_data[ccu_pkg::ALT_SEL_BIT] = alt_pin_select_q;
            end
            ccu_pkg::OFF_STATUS: begin
                rd_data[ccu_pkg::STAT_IRQ_BIT] = unit_irq_flag_q;
                rd_data[ccu_pkg::STAT_OVF_BIT] = timer_overflow_flag_q;
            end
            ccu_pkg::OFF_CONV_CTRL: begin
                rd_data[ccu_pkg::CONV_ON_BIT] = converter_on_q;
                rd_data[ccu_pkg::CONV_GO_BIT] = converter_start_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (access && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~rd_hit;
            prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

endmodule

// *** test/ccu_unit_sva.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module ccu_unit_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready_q,
    input wire logic pslverr_q,
    // Pins and status
    input wire logic pin_pri_oe_q,
    input wire logic pin_alt_oe_q,
    input wire logic unit_irq_flag_q,
    input wire logic timer_overflow_flag_q,
    input wire logic converter_start_q,
    input wire logic special_event_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // One wait state, then a single answer cycle
    sequence s_answer;
        !pready_q ##1 pready_q ##1 !pready_q;
    endsequence
    apb_one_wait_a: assert property (psel && !penable |=> s_answer)
        else $error("answer timing wrong");
    apb_err_ready_a: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    trig_pulse_a: assert property (special_event_q |=> !special_event_q)
        else $error("trigger not a pulse");
    trig_pin_free_a: assert property (special_event_q |->
        !pin_pri_oe_q && !pin_alt_oe_q)
        else $error("pin driven in trigger mode");
    trig_no_ovf_a: assert property (
        special_event_q && !timer_overflow_flag_q |-> !timer_overflow_flag_q [*8])
        else $error("trigger set overflow");
    trig_flag_a: assert property (special_event_q |-> ##[0:1] unit_irq_flag_q)
        else $error("trigger without flag");
    conv_go_src_a: assert property ($rose(converter_start_q) |->
        special_event_q || $past(special_event_q) || $past(psel && penable && pwrite))
        else $error("go bit without cause");
    flag_sticky_a: assert property ($fell(unit_irq_flag_q) |->
        $past(psel && penable && pwrite))
        else $error("flag fell by itself");
endmodule
bind ccu_unit ccu_unit_sva ccu_unit_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .pin_pri_oe_q(pin_pri_oe_q), .pin_alt_oe_q(pin_alt_oe_q),
    .unit_irq_flag_q(unit_irq_flag_q), .timer_overflow_flag_q(timer_overflow_flag_q),
    .converter_start_q(converter_start_q), .special_event_q(special_event_q));

// *** test/ccu_far_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Event pin source and external timer clock
// ---------------------------------------------------------------
module ccu_far_model (
    // Clock
    input wire logic clk_sys,
    // Far side lines
    output logic pin_lvl,
    output logic ext_clk
);
    initial begin
        pin_lvl = 1'b0;
        ext_clk = 1'b0;
    end
    // Slow edges so each clears the synchroniser; the clock stands still afterwards
    task automatic edges(input logic sel, input int n);
        repeat (2 * n) begin
            repeat (6) @(posedge clk_sys);
            if (sel) ext_clk <= ~ext_clk;
            else pin_lvl <= ~pin_lvl;
        end
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, lerr, pin_lvl, ext_clk, pri_o, pri_oe, alt_o, alt_oe, irq, ovf;
    logic go, sev;
    logic [7:0] rd;
    int error_cnt = 0, check_count = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    ccu_unit ccu_unit_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .pin_pri_in(pin_lvl), .pin_pri_out_q(pri_o),
        .pin_pri_oe_q(pri_oe), .pin_alt_in(pin_lvl), .pin_alt_out_q(alt_o), .pin_alt_oe_q(alt_oe),
        .ext_timer_clk(ext_clk), .sleep_mode(sleep_mode), .unit_irq_flag_q(irq),
        .timer_overflow_flag_q(ovf), .converter_start_q(go), .special_event_q(sev));
    ccu_far_model ccu_far_model_inst (.clk_sys(clk_sys), .pin_lvl(pin_lvl), .ext_clk(ext_clk));
    // Request held until ready is seen at an edge; a quiet cycle keeps drivers apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready_q !== 1'b1);
        rd = prdata_q[7:0];
        lerr = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic pe(input logic sel, input int n);
        ccu_far_model_inst.edges(sel, n);
    endtask
    // Unit off first so the prescaler starts empty; timer stopped at 1234
    task automatic arm(input logic [7:0] mode, input logic [7:0] mlo);
        w(8'h00, 8'h00);
        w(8'h1C, 8'h03);
        w(8'h14, 8'h00);
        w(8'h0C, 8'h34);
        w(8'h10, 8'h12);
        w(8'h04, mlo);
        w(8'h08, 8'h12);
        w(8'h00, mode);
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h00, 8'h00);
        `CHK("ctrl_rst", 8'h00, rd)
        w(8'h00, 8'hF5);
        apb(1'b0, 8'h00, 8'h00);
        `CHK("ctrl", 8'hF5, rd)
        apb(1'b0, 8'h40, 8'h00);
        `CHK("unmapped", 1'b1, lerr)
    endtask
    task automatic t_cmp;
        logic [7:0] modes [4] = '{8'h08, 8'h09, 8'h0A, 8'h02};
        for (int i = 0; i < 4; i++) begin
            w(8'h18, 8'(i > 1));
            arm(modes[i], 8'h40);
            w(8'h14, 8'h01);
            repeat (200) if (irq !== 1'b1) @(posedge clk_sys);
            `CHK("cmp_irq", 1'b1, irq)
            repeat (3) @(posedge clk_sys);
            `CHK("cmp_pin", i % 3 == 0, i > 1 ? alt_o : pri_o)
            `CHK("alt_oe", i == 3, alt_oe)
        end
        w(8'h00, 8'h00);
        repeat (3) @(posedge clk_sys);
        `CHK("latch_low", 1'b0, alt_o)
        w(8'h18, 8'h00);
    endtask
    task automatic t_special;
        w(8'h20, 8'h01);
        arm(8'h0B, 8'h40);
        w(8'h14, 8'h01);
        repeat (200) if (sev !== 1'b1) @(posedge clk_sys);
        `CHK("trig_oe", 1'b0, pri_oe)
        repeat (6) @(posedge clk_sys);
        apb(1'b0, 8'h0C, 8'h00);
        `CHK("tmr_reset", 1'b1, rd < 8'h08)
        `CHK("no_ovf", 1'b0, ovf)
        `CHK("conv_go", 1'b1, go)
        w(8'h20, 8'h00);
    endtask
    task automatic t_capture;
        arm(8'h05, 8'h40);
        pe(1'b0, 1);
        `CHK("cap_irq", 1'b1, irq)
        apb(1'b0, 8'h04, 8'h00);
        `CHK("cap_lo", 8'h34, rd)
        arm(8'h04, 8'h40);
        pe(1'b0, 1);
        `CHK("cap_fall", 1'b1, irq)
        arm(8'h06, 8'h40);
        pe(1'b0, 2);
        arm(8'h06, 8'h40);
        pe(1'b0, 3);
        `CHK("pre_clr", 1'b0, irq)
        pe(1'b0, 1);
        `CHK("fourth", 1'b1, irq)
        arm(8'h07, 8'h40);
        pe(1'b0, 3);
        w(8'h00, 8'h06);
        pe(1'b0, 1);
        `CHK("switch_keep", 1'b1, irq)
    endtask
    task automatic t_sleep;
        arm(8'h00, 8'h40);
        sleep_mode <= 1'b1;
        w(8'h14, 8'h01);
        repeat (40) @(posedge clk_sys);
        apb(1'b0, 8'h0C, 8'h00);
        `CHK("sleep_hold", 8'h34, rd)
        sleep_mode <= 1'b0;
        repeat (40) @(posedge clk_sys);
        apb(1'b0, 8'h0C, 8'h00);
        `CHK("resumed", 1'b1, rd > 8'h34)
        arm(8'h00, 8'h40);
        w(8'h14, 8'h03);
        sleep_mode <= 1'b1;
        pe(1'b1, 5);
        sleep_mode <= 1'b0;
        apb(1'b0, 8'h0C, 8'h00);
        `CHK("ext_count", 8'h39, rd)
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard, far above the roughly one thousand cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_cmp();
        t_special();
        t_capture();
        t_sleep();
        finish_test();
    end
endmodule
